// *** rtl/hfl_pkg.sv ***
// package: register map, fields, reset values and bus widths of the fifo level block
package hfl_pkg;
  // ****************
  // link widths
  // ****************
  localparam int ADDR_W = 8;                          // host bus byte address width
  localparam int DATA_W = 32;                         // host bus data width
  // ****************
  // device register offsets
  // ****************
  localparam logic [7:0] OFF_IRQ_STS   = 8'h58;       // irq_status_reg
  localparam logic [7:0] OFF_IRQ_EN    = 8'h5c;       // interrupt enable
  localparam logic [7:0] OFF_FIFO_LVL  = 8'h68;       // fifo_level_thresholds
  localparam logic [7:0] OFF_RX_CFG    = 8'h6c;       // receive_config
  // ****************
  // field positions
  // ****************
  localparam int TX_AVAIL_LSB  = 24;                  // tx data available level 31:24
  localparam int TX_STS_LSB    = 16;                  // tx status level 23:16
  localparam int RSV_LVL_LSB   = 8;                   // reserved byte 15:8
  localparam int RX_STS_LSB    = 0;                   // rx status level 7:0
  localparam int EA_LSB        = 30;                  // rx_end_align 31:30
  localparam int BUDGET_LSB    = 16;                  // rx_read_budget 27:16
  localparam int BUDGET_W      = 12;                  // budget width
  localparam int PURGE_BIT     = 15;                  // receive discard
  localparam int OFS_LSB       = 8;                   // rx_start_offset 12:8
  localparam int BIT_RXD       = 20;                  // rx dma countdown irq
  localparam int BIT_TX_SPACE_AVAIL_IRQ      = 9;                   // tx_space_avail_irq
  localparam int BIT_TX_STATUS_LEVEL_IRQ      = 7;                   // tx_status_level_irq
  localparam int BIT_RX_STATUS_LEVEL_IRQ      = 3;                   // rx_status_level_irq
  // ****************
  // reset values and masks
  // ****************
  localparam logic [31:0] RST_FIFO_LVL = 32'h4800_0000;
  localparam logic [31:0] RST_RX_CFG   = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_EN   = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK     = 32'h0010_0288; // implemented irq bits
  localparam logic [31:0] LVL_RSV_MASK = 32'h0000_ff00; // reserved level byte
  // ****************
  // end alignment codes
  // ****************
  localparam logic [1:0] EA_4B  = 2'h0;
  localparam logic [1:0] EA_16B = 2'h1;
  localparam logic [1:0] EA_32B = 2'h2;
  // ****************
  // host controller apb map
  // ****************
  localparam logic [7:0] APB_CTRL   = 8'h00;          // go bit0, write bit1, addr 15:8
  localparam logic [7:0] APB_WDATA  = 8'h04;          // data for link writes
  localparam logic [7:0] APB_RDATA  = 8'h08;          // data from last link read
  localparam logic [7:0] APB_STATUS = 8'h0c;          // busy bit0
  localparam int CTRL_GO    = 0;
  localparam int CTRL_WR    = 1;
  localparam int CTRL_ADDR  = 8;
endpackage

// *** rtl/hfl_if.sv ***
// interface: sram-like host bus between the host controller and the fifo level device
interface hfl_if;
  import hfl_pkg::*;
  logic [ADDR_W-1:0] hbAddr;                          // register byte address
  logic              hbWr;                            // one-cycle write strobe
  logic              hbRd;                            // one-cycle read strobe
  logic [DATA_W-1:0] hbWdata;                         // write data
  logic [DATA_W-1:0] hbRdata;                         // read data, valid with hbAck
  logic              hbAck;                           // one-cycle completion pulse
  modport device (input hbAddr, hbWr, hbRd, hbWdata, output hbRdata, hbAck);
  modport host   (output hbAddr, hbWr, hbRd, hbWdata, input hbRdata, hbAck);
endinterface

// *** rtl/hfl_device.sv ***
// device end: fifo level interrupts, receive configuration and read budget
//
// Implementation choice: the sram-like host bus slave port.
module hfl_device
  import hfl_pkg::*;
(
  input  wire logic       clk,                        // 50 mhz system clock
  input  wire logic       rst_n,                      // synchronous reset
  hfl_if.device           hb,                         // host bus
  input  wire logic [7:0] txFreeBlocks,               // tx data free space, 64-byte blocks
  input  wire logic [7:0] txStatusUsed,               // tx status used, dwords
  input  wire logic [7:0] rxStatusUsed,               // rx status used, dwords
  input  wire logic       rxDwordRead,                // pulse: one dword read from rx data
  input  wire logic [2:0] rxPktDwords,                // dwords of current packet, mod 8
  output logic            irq,                        // interrupt output, active high
  output logic            rxPurge,                    // pulse: purge rx data and status
  output logic      [1:0] rxEndAlign,                 // active end alignment code
  output logic      [2:0] rxPadDwords,                // dwords of padding to append
  output logic      [4:0] rxStartOffset               // active start offset, bytes
);
  // ****************
  // register state
  // ****************
  logic [31:0]         fifoLvl;                       // threshold register
  logic [1:0]          cfgAlign;                      // programmed end alignment
  logic [4:0]          cfgOffset;                     // programmed start offset
  logic [BUDGET_W-1:0] budget;                        // running read budget
  logic [31:0]         irqEn;                         // interrupt enables
  logic [31:0]         irqSts;                        // sticky interrupt status
  logic [2:0]          dwOffset;                      // applied dword part of offset
  logic                wrLvl;                         // write to thresholds
  logic                wrCfg;                         // write to receive config
  logic                wrEn;                          // write to enables
  logic                wrSts;                         // write to status
  logic                budgetDone;                    // budget reaches zero this cycle
  logic [31:0]         setSts;                        // status set terms
  logic [31:0]         rdMux;                         // read data select
  logic [2:0]          padMask;                       // alignment mask in dwords

  // ****************
  // address decode
  // ****************
  // one write strobe per register
  always_comb begin
    wrLvl = hb.hbWr && (hb.hbAddr == OFF_FIFO_LVL);
    wrCfg = hb.hbWr && (hb.hbAddr == OFF_RX_CFG);
    wrEn  = hb.hbWr && (hb.hbAddr == OFF_IRQ_EN);
    wrSts = hb.hbWr && (hb.hbAddr == OFF_IRQ_STS);
  end

  // ****************
  // threshold register
  // ****************
  // all bits stored; reserved byte kept as written by the host
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifoLvl <= RST_FIFO_LVL;
    end else if (wrLvl) begin
      fifoLvl <= hb.hbWdata;
    end
  end

  // ****************
  // receive configuration
  // ****************
  // alignment and offset fields
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgAlign  <= RST_RX_CFG[EA_LSB +: 2];
      cfgOffset <= RST_RX_CFG[OFS_LSB +: 5];
    end else if (wrCfg) begin
      cfgAlign  <= hb.hbWdata[EA_LSB +: 2];
      cfgOffset <= hb.hbWdata[OFS_LSB +: 5];
    end
  end

  // purge pulse, never stored as a bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxPurge <= 1'b0;
    end else begin
      rxPurge <= wrCfg && hb.hbWdata[PURGE_BIT];
    end
  end

  // ****************
  // read budget
  // ****************
  // terminal count: last dword of the budget is read
  assign budgetDone = rxDwordRead && (budget == 12'h001) && !wrCfg;

  // write replaces the count even mid-run; reads decrement a nonzero count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      budget <= RST_RX_CFG[BUDGET_LSB +: BUDGET_W];
    end else if (wrCfg) begin
      budget <= hb.hbWdata[BUDGET_LSB +: BUDGET_W];
    end else if (rxDwordRead && (budget != 12'h000)) begin
      budget <= budget - 12'h001;
    end
  end

  // ****************
  // start offset
  // ****************
  // dword part waits for the next dword read; a purge also loads it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dwOffset <= RST_RX_CFG[OFS_LSB+2 +: 3];
    end else if (rxDwordRead || rxPurge) begin
      dwOffset <= cfgOffset[4:2];
    end
  end

  // byte part is only changed while halted, so it passes straight through
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxStartOffset <= 5'h00;
    end else begin
      rxStartOffset <= {dwOffset, cfgOffset[1:0]};
    end
  end

  // ****************
  // end alignment padding
  // ****************
  // mask of dwords per alignment unit; reserved code pads nothing
  always_comb begin
    case (cfgAlign)
      EA_16B:  padMask = 3'h3;
      EA_32B:  padMask = 3'h7;
      default: padMask = 3'h0;
    endcase
  end

  // pad = dwords up to the next alignment boundary
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxEndAlign  <= 2'h0;
      rxPadDwords <= 3'h0;
    end else begin
      rxEndAlign  <= cfgAlign;
      rxPadDwords <= (3'h0 - rxPktDwords) & padMask;
    end
  end

  // ****************
  // interrupt enables
  // ****************
  // only implemented enable bits are stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqEn <= RST_IRQ_EN;
    end else if (wrEn) begin
      irqEn <= hb.hbWdata & IRQ_MASK;
    end
  end

  // ****************
  // interrupt status
  // ****************
  // level conditions sampled every cycle
  always_comb begin
    setSts = 32'h0000_0000;
    setSts[BIT_TX_SPACE_AVAIL_IRQ] = txFreeBlocks > fifoLvl[TX_AVAIL_LSB +: 8];
    setSts[BIT_TX_STATUS_LEVEL_IRQ] = txStatusUsed > fifoLvl[TX_STS_LSB +: 8];
    setSts[BIT_RX_STATUS_LEVEL_IRQ] = rxStatusUsed > fifoLvl[RX_STS_LSB +: 8];
    setSts[BIT_RXD]  = budgetDone;
  end

  // write one clears; a set in the same cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqSts <= 32'h0000_0000;
    end else begin
      irqSts <= ((irqSts & ~(wrSts ? hb.hbWdata : 32'h0000_0000)) | setSts)
                & IRQ_MASK;
    end
  end

  // output gated by enables only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqSts & irqEn);
    end
  end

  // ****************
  // read path
  // ****************
  // register select; unmapped addresses read zero
  always_comb begin
    case (hb.hbAddr)
      OFF_FIFO_LVL: rdMux = fifoLvl;
      OFF_RX_CFG:   rdMux = {cfgAlign, 2'h0, budget, 3'h0, cfgOffset, 8'h00};
      OFF_IRQ_EN:   rdMux = irqEn;
      OFF_IRQ_STS:  rdMux = irqSts;
      default:      rdMux = 32'h0000_0000;
    endcase
  end

  // answer every strobe one cycle later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hb.hbAck   <= 1'b0;
      hb.hbRdata <= 32'h0000_0000;
    end else begin
      hb.hbAck   <= hb.hbWr || hb.hbRd;
      hb.hbRdata <= hb.hbRd ? rdMux : 32'h0000_0000;
    end
  end
endmodule

// *** rtl/hfl_host.sv ***
// host end: apb-programmed controller that runs single transfers on the host bus
module hfl_host
  import hfl_pkg::*;
(
  input  wire logic        clk,                       // 50 mhz system clock
  input  wire logic        rst_n,                     // synchronous reset
  hfl_if.host              hb,                        // host bus
  input  wire logic        psel,                      // apb select
  input  wire logic        penable,                   // apb access phase
  input  wire logic        pwrite,                    // apb direction
  input  wire logic  [7:0] paddr,                     // apb byte address
  input  wire logic [31:0] pwdata,                    // apb write data
  output logic      [31:0] prdata,                    // apb read data
  output logic             pready,                    // apb ready
  output logic             pslverr                    // apb error, always low
);
  // ****************
  // state
  // ****************
  typedef enum logic [1:0] {HFL_IDLE, HFL_STROBE, HFL_WAIT} hfl_state_t;
  hfl_state_t  state;                                 // transfer sequencer
  logic [7:0]  cmdAddr;                               // device register address
  logic        cmdWr;                                 // transfer direction
  logic [31:0] cmdWdata;                              // data for device writes
  logic [31:0] linkRdata;                             // data from last device read
  logic        apbSetup;                              // setup cycle of an apb transfer
  logic        apbWrite;                              // apb write completes this cycle
  logic        goReq;                                 // software starts a transfer

  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite;
  assign goReq    = apbWrite && (paddr == APB_CTRL) && pwdata[CTRL_GO] && (state == HFL_IDLE);

  // ****************
  // apb slave
  // ****************
  // no wait states: ready in the first access cycle of every transfer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apbSetup;
      pslverr <= 1'b0;
      case (paddr)
        APB_CTRL:   prdata <= {16'h0000, cmdAddr, 6'h00, cmdWr, 1'b0};
        APB_WDATA:  prdata <= cmdWdata;
        APB_RDATA:  prdata <= linkRdata;
        APB_STATUS: prdata <= {31'h0, state != HFL_IDLE};
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

  // command registers, frozen while a transfer runs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmdAddr  <= 8'h00;
      cmdWr    <= 1'b0;
      cmdWdata <= 32'h0000_0000;
    end else if (apbWrite && (state == HFL_IDLE)) begin
      if (paddr == APB_CTRL) begin
        cmdAddr <= pwdata[CTRL_ADDR +: 8];
        cmdWr   <= pwdata[CTRL_WR];
      end else if (paddr == APB_WDATA) begin
        cmdWdata <= pwdata;
      end
    end
  end

  // ****************
  // host bus sequencer
  // ****************
  // strobe one cycle, then wait for the acknowledge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= HFL_IDLE;
      hb.hbAddr  <= 8'h00;
      hb.hbWr    <= 1'b0;
      hb.hbRd    <= 1'b0;
      hb.hbWdata <= 32'h0000_0000;
    end else begin
      case (state)
        HFL_IDLE: begin
          if (goReq) begin
            state     <= HFL_STROBE;
            hb.hbAddr <= cmdAddr;
            hb.hbWr   <= cmdWr;
            hb.hbRd   <= !cmdWr;
            // reserved threshold byte always goes out as zero
            hb.hbWdata <= (cmdAddr == OFF_FIFO_LVL) ? (cmdWdata & ~LVL_RSV_MASK)
                                                    : cmdWdata;
          end
        end
        HFL_STROBE: begin
          state   <= HFL_WAIT;
          hb.hbWr <= 1'b0;
          hb.hbRd <= 1'b0;
        end
        HFL_WAIT: begin
          if (hb.hbAck) begin
            state <= HFL_IDLE;
          end
        end
        default: state <= HFL_IDLE;
      endcase
    end
  end

  // capture read data on the acknowledge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      linkRdata <= 32'h0000_0000;
    end else if ((state == HFL_WAIT) && hb.hbAck && !cmdWr) begin
      linkRdata <= hb.hbRdata;
    end
  end
endmodule

// *** verif/hfl_assertions.sv ***
// checker: link handshake, purge, irq masking and receive output relations
module hfl_assertions
  import hfl_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] hbAddr,
  input wire logic              hbWr,
  input wire logic              hbRd,
  input wire logic [DATA_W-1:0] hbWdata,
  input wire logic [DATA_W-1:0] hbRdata,
  input wire logic              hbAck,
  input wire logic              irq,
  input wire logic              rxPurge,
  input wire logic [1:0]        rxEndAlign,
  input wire logic [2:0]        rxPadDwords,
  input wire logic [2:0]        rxPktDwords
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // helper logic
  // ****************
  logic        cfgWr;                                 // config write on the link
  logic        purgeReq;                              // config write with discard set
  logic [1:0]  eaReq;                                 // alignment field on the link
  logic [31:0] enShadow;                              // copy of the enable register
  assign cfgWr    = hbWr && (hbAddr == OFF_RX_CFG);
  assign purgeReq = cfgWr && hbWdata[PURGE_BIT];
  assign eaReq    = hbWdata[EA_LSB+1:EA_LSB];
  // follows enable writes on the same edge as the device does
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enShadow <= RST_IRQ_EN;
    end else if (hbWr && (hbAddr == OFF_IRQ_EN)) begin
      enShadow <= hbWdata & IRQ_MASK;
    end
  end
  // pad mask per alignment code; reserved code pads nothing
  function automatic logic [2:0] padMask(input logic [1:0] code);
    case (code)
      EA_16B:  padMask = 3'h3;
      EA_32B:  padMask = 3'h7;
      default: padMask = 3'h0;
    endcase
  endfunction
  default clocking cbk @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************
  // assertions
  // ****************
  a_ack_follows:
    assert property ((hbWr || hbRd) |=> hbAck) else $error("strobe without ack");
  a_ack_single:
    assert property (hbAck |=> !hbAck) else $error("ack longer than one cycle");
  a_rdata_idle:
    assert property (!hbAck |-> (hbRdata == '0)) else $error("read data outside ack");
  a_purge_on_write:
    assert property (purgeReq |=> rxPurge) else $error("no purge after discard write");
  a_purge_cause:
    assert property (rxPurge |-> $past(purgeReq)) else $error("purge without discard write");
  a_lvl_rsv_zero:
    assert property ((hbWr && (hbAddr == OFF_FIFO_LVL)) |-> ((hbWdata & LVL_RSV_MASK) == '0))
      else $error("reserved level byte not zero");
  a_irq_masked:
    assert property (((enShadow == '0) && ($past(enShadow) == '0)) |-> !irq)
      else $error("irq with all sources disabled");
  a_align_follows:
    assert property (cfgWr |=> ##1 (rxEndAlign == $past(eaReq, 2)))
      else $error("alignment output not updated");
  a_pad_value:
    assert property (($past(rst_n) && $stable(rxEndAlign)) |->
      (rxPadDwords == ((3'h0 - $past(rxPktDwords)) & padMask(rxEndAlign))))
      else $error("pad dword count wrong");
  c_purge: cover property (purgeReq);
  c_read:  cover property (hbRd ##1 hbAck);
  c_irq:   cover property ($rose(irq));
  c_pad:   cover property (rxPadDwords != 3'h0);
endmodule

// *** verif/testbench.sv ***
// testbench: apb-driven host end joined to the device end over the link
module testbench
  import hfl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, psel, penable, pwrite, pready, irq, rxPurge, rxDwordRead;
  logic        pslverr, errSeen;                      // apb error, error seen at any ready edge
  logic [7:0]  paddr;                                 // apb byte address
  logic [31:0] pwdata, prdata, q;                     // apb data, last read
  logic [7:0]  srcLvl [3];                            // tx free, tx used, rx used
  logic [2:0]  rxPktDwords, rxPadDwords;
  logic [1:0]  rxEndAlign;
  logic [4:0]  rxStartOffset;
  int          errors, samples_checked, purgeCount, i;
  localparam logic [7:0]  LVL  [3] = '{8'h10, 8'h05, 8'h07};
  localparam logic [31:0] BITS [3] = '{32'h200, 32'h80, 32'h8};
  localparam logic [2:0]  PADS [4] = '{3'h0, 3'h1, 3'h5, 3'h0};
  hfl_if hbIf ();
  hfl_host hfl_host_inst (.clk(clk), .rst_n(rst_n), .hb(hbIf), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  hfl_device hfl_device_inst (.clk(clk), .rst_n(rst_n), .hb(hbIf), .txFreeBlocks(srcLvl[0]),
    .txStatusUsed(srcLvl[1]), .rxStatusUsed(srcLvl[2]), .rxDwordRead(rxDwordRead),
    .rxPktDwords(rxPktDwords), .irq(irq), .rxPurge(rxPurge), .rxEndAlign(rxEndAlign),
    .rxPadDwords(rxPadDwords), .rxStartOffset(rxStartOffset));
  hfl_assertions hfl_assertions_inst (.clk(clk), .rst_n(rst_n), .hbAddr(hbIf.hbAddr),
    .hbWr(hbIf.hbWr), .hbRd(hbIf.hbRd), .hbWdata(hbIf.hbWdata), .hbRdata(hbIf.hbRdata),
    .hbAck(hbIf.hbAck), .irq(irq), .rxPurge(rxPurge), .rxEndAlign(rxEndAlign),
    .rxPadDwords(rxPadDwords), .rxPktDwords(rxPktDwords));
  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // counts purge pulses seen at the device output
  always @(posedge clk) begin
    if (rxPurge === 1'b1) purgeCount++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // verdict and end of run
  task automatic close_out();
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer: setup, access until pready, then an idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    errSeen = errSeen | (pslverr !== 1'b0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // one link transfer: data, address and direction, go, wait idle, fetch
  task automatic link(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] s;
    apb(1'b1, APB_WDATA, d, s);
    apb(1'b1, APB_CTRL, {16'h0, a, 6'h0, wr, 1'b0}, s);
    apb(1'b1, APB_CTRL, {16'h0, a, 6'h0, wr, 1'b1}, s);
    s = 32'h1;
    while (s[0] !== 1'b0) apb(1'b0, APB_STATUS, 32'h0, s);
    apb(1'b0, APB_RDATA, 32'h0, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    link(1'b0, a, 32'h0);
    check(q & m, e);
  endtask
  // one-cycle dword read pulses
  task automatic pulse(input int n);
    repeat (n) begin
      rxDwordRead <= 1'b1;
      @(posedge clk);
      rxDwordRead <= 1'b0;
      @(posedge clk);
    end
  endtask
  // watchdog
  initial begin
    tick(40000);
    errors++;
    close_out();
  end
  // ****************
  // tests
  // ****************
  initial begin
    errSeen = 1'b0;
    {rst_n, psel, penable, pwrite, rxDwordRead} <= 5'h0;
    {paddr, pwdata, rxPktDwords} <= '0;
    srcLvl <= '{8'h0, 8'h0, 8'h0};
    tick(8);
    rst_n <= 1'b1;
    tick(1);
    rdc(OFF_FIFO_LVL, '1, RST_FIFO_LVL);
    rdc(OFF_IRQ_EN, '1, 32'h0);
    rdc(OFF_RX_CFG, '1, 32'h0);
    rdc(OFF_IRQ_STS, IRQ_MASK, 32'h0);
    rdc(8'h40, '1, 32'h0);
    link(1'b1, OFF_FIFO_LVL, 32'h1005_ff07);
    rdc(OFF_FIFO_LVL, '1, 32'h1005_0007);
    // each level source: equal stays clear, one above sets, sticky, w1c
    for (i = 0; i < 3; i++) begin
      srcLvl[i] <= LVL[i];
      link(1'b1, OFF_IRQ_STS, IRQ_MASK);
      rdc(OFF_IRQ_STS, IRQ_MASK, 32'h0);
      srcLvl[i] <= LVL[i] + 8'h1;
      tick(2);
      rdc(OFF_IRQ_STS, IRQ_MASK, BITS[i]);
      srcLvl[i] <= LVL[i];
      rdc(OFF_IRQ_STS, IRQ_MASK, BITS[i]);
      link(1'b1, OFF_IRQ_STS, BITS[i]);
      rdc(OFF_IRQ_STS, IRQ_MASK, 32'h0);
    end
    // enables gate the irq output, status stays regardless
    link(1'b1, OFF_IRQ_EN, 32'hffff_ffff);
    rdc(OFF_IRQ_EN, '1, IRQ_MASK);
    link(1'b1, OFF_IRQ_EN, 32'h1 << BIT_TX_SPACE_AVAIL_IRQ);
    rdc(OFF_IRQ_EN, '1, 32'h0000_0200);
    check({31'h0, irq}, 32'h0);
    srcLvl[0] <= 8'h11;
    tick(3);
    check({31'h0, irq}, 32'h1);
    link(1'b1, OFF_IRQ_EN, 32'h1 << BIT_TX_STATUS_LEVEL_IRQ);
    tick(2);
    check({31'h0, irq}, 32'h0);
    rdc(OFF_IRQ_STS, IRQ_MASK, 32'h200);
    srcLvl[0] <= 8'h10;
    link(1'b1, OFF_IRQ_STS, IRQ_MASK);
    // read budget countdown, rewrite in mid-count
    link(1'b1, OFF_IRQ_EN, 32'h1 << BIT_RXD);
    link(1'b1, OFF_RX_CFG, 32'h0003_0000);
    pulse(2);
    rdc(OFF_RX_CFG, '1, 32'h0001_0000);
    link(1'b1, OFF_RX_CFG, 32'h0002_0000);
    pulse(1);
    rdc(OFF_RX_CFG, '1, 32'h0001_0000);
    rdc(OFF_IRQ_STS, IRQ_MASK, 32'h0);
    check({31'h0, irq}, 32'h0);
    pulse(1);
    tick(2);
    check({31'h0, irq}, 32'h1);
    rdc(OFF_IRQ_STS, IRQ_MASK, 32'h0010_0000);
    link(1'b1, OFF_RX_CFG, 32'h0fff_0000);
    rdc(OFF_RX_CFG, '1, 32'h0fff_0000);
    link(1'b1, OFF_IRQ_STS, IRQ_MASK);
    // every end alignment code, chosen between packets
    rxPktDwords <= 3'h3;
    for (i = 0; i < 4; i++) begin
      link(1'b1, OFF_RX_CFG, 32'(i) << EA_LSB);
      tick(2);
      check({30'h0, rxEndAlign}, 32'(i));
      check({29'h0, rxPadDwords}, {29'h0, PADS[i]});
    end
    // purge, then offset change: low bits at once, dword bits at next read
    link(1'b1, OFF_RX_CFG, 32'h0000_8000);
    check(32'(purgeCount), 32'h1);
    rdc(OFF_RX_CFG, 32'h0000_8000, 32'h0);
    link(1'b1, OFF_RX_CFG, 32'h0000_1700);
    tick(2);
    check({27'h0, rxStartOffset}, 32'h03);
    pulse(1);
    tick(2);
    check({27'h0, rxStartOffset}, 32'h17);
    link(1'b1, OFF_RX_CFG, 32'h0000_0b00);
    tick(2);
    check({27'h0, rxStartOffset}, 32'h17);
    pulse(1);
    tick(2);
    check({27'h0, rxStartOffset}, 32'h0b);
    rdc(OFF_RX_CFG, 32'h0000_1f00, 32'h0000_0b00);
    // host controller readback: last command was a read of the receive config
    apb(1'b0, APB_CTRL, 32'h0, q);
    check(q, 32'h0000_6c00);
    apb(1'b0, APB_WDATA, 32'h0, q);
    check(q, 32'h0);
    check({31'h0, errSeen}, 32'h0);
    close_out();
  end
endmodule
